/* rtl/tcs_top.sv */
/*
  Torque command selection, smoothing, analog scaling and dual mode switching.
  Assumes digital inputs arrive asynchronously; analog sample in mV is on CLK_I.
*/
// Strobed register access was chosen for this implementation.
// What this block does
// - Both selects low in T mode: torque from analog input, -10 V to +10 V.
// - Both selects low in Tz mode: torque command forced to zero.
// - Select codes 01,10,11 pick stored setpoints one to three, within +-300 %.
// - A written stored setpoint applies at once; select changes apply while servo is on.
// - Input level 0 means off, level 1 means on.
// - In position and speed modes the torque source is a limit, not a demand.
// - Low-pass filter with time constant in ms; zero passes unfiltered.
// - Torque percent equals input volts times scale setting over ten.
// - Same scale turns analog input into a torque limit in position and speed.
// - Torque selection honoured only while servo is on.
// - Dual mode codes 06,07,08,09,0A and 0D.
// - No dual mode pairs the zero-reference speed or torque modes.
// - Pulse/speed takes pulses; internal/speed takes stored position setpoints.
// - Speed/position switch on: speed mode, trigger ignored.
// - Switch off: motor held, no position, until trigger rising edge.
// - Trigger rising edge latches six-bit target and starts the move.
// - Switch back on returns to speed mode at once.
// - Speed/torque switch on: torque mode with torque select inputs.
// - Speed/torque switch off: follow speed select, torque again when on.
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
module tcs_top
  import tcs_pkg::*;
#(
  parameter int CTRL_CYCLES = `TCS_CTRL_CYCLE_US * 1000 / `TCS_CLK_NS
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic SERVO_ON_I,
  input wire logic [1:0] TORQUE_SELECT_I,
  input wire logic [1:0] SPEED_SELECT_I,
  input wire logic [5:0] POSITION_SELECT_I,
  input wire logic POSITION_TRIGGER_I,
  input wire logic SPEED_POS_SWITCH_I,
  input wire logic SPEED_TORQUE_SWITCH_I,
  input wire logic signed [15:0] ANALOG_REF_MV_I,
  output logic signed [19:0] TORQUE_CMD_O,
  output logic TORQUE_IS_LIMIT_O,
  output logic [1:0] ACTIVE_MODE_O,
  output logic [1:0] SPEED_SEL_O,
  output logic POS_FROM_PULSES_O,
  output logic MOTOR_HOLD_O,
  output logic POS_MOVE_O,
  output logic [5:0] POS_TARGET_O
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int NDI = 14;
  logic [NDI-1:0] di_meta_reg;
  logic [NDI-1:0] di_reg;
  logic trig_d_reg;
  logic servo_d_reg;
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      di_meta_reg <= '0;
      di_reg <= '0;
    end else begin
      di_meta_reg <= {SERVO_ON_I, TORQUE_SELECT_I, SPEED_SELECT_I, POSITION_SELECT_I,
                      POSITION_TRIGGER_I, SPEED_POS_SWITCH_I, SPEED_TORQUE_SWITCH_I};
      di_reg <= di_meta_reg;
    end
  end
  // Level 1 is on, level 0 is off
  logic servo_s, trig_s, sp_sw, st_sw;
  logic [1:0] tsel_s, ssel_s;
  logic [5:0] psel_s;
  assign servo_s = di_reg[13];
  assign tsel_s = di_reg[12:11];
  assign ssel_s = di_reg[10:9];
  assign psel_s = di_reg[8:3];
  assign trig_s = di_reg[2];
  assign sp_sw = di_reg[1];
  assign st_sw = di_reg[0];
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      trig_d_reg <= 1'b0;
      servo_d_reg <= 1'b0;
    end else begin
      trig_d_reg <= trig_s;
      servo_d_reg <= servo_s;
    end
  end
  logic trig_rise;
  logic servo_rise;
  assign trig_rise = trig_s & ~trig_d_reg;
  assign servo_rise = servo_s & ~servo_d_reg;
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [15:0] filt_reg;
  logic [15:0] scale_reg;
  logic [7:0] mode_reg;
  logic signed [15:0] sp_reg [1:3];
  logic mode_ok;
  always_comb begin
    case (REG_WDATA_I[7:0])
      `TCS_M_PT, `TCS_M_PR, `TCS_M_S, `TCS_M_T, `TCS_M_SZ, `TCS_M_TZ,
      `TCS_M_PTS, `TCS_M_PTT, `TCS_M_PRS, `TCS_M_PRT, `TCS_M_ST, `TCS_M_PTPR: mode_ok = 1'b1;
      default: mode_ok = 1'b0;
    endcase
  end
  logic sp_ok;
  assign sp_ok = ($signed(REG_WDATA_I) <= $signed(`TCS_SP_MAX)) &&
                 ($signed(REG_WDATA_I) >= -$signed(`TCS_SP_MAX));
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      filt_reg <= `TCS_RST_FILT;
      scale_reg <= `TCS_RST_SCALE;
      mode_reg <= `TCS_RST_MODE;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == `TCS_ADDR_FILT && REG_WDATA_I <= `TCS_FILT_MAX) begin
        filt_reg <= REG_WDATA_I;
      end
      if (REG_ADDR_I == `TCS_ADDR_SCALE && REG_WDATA_I <= `TCS_SCALE_MAX) begin
        scale_reg <= REG_WDATA_I;
      end
      if (REG_ADDR_I == `TCS_ADDR_MODE && mode_ok) begin
        mode_reg <= REG_WDATA_I[7:0];
      end
    end
  end
  // Stored setpoints, out-of-range writes dropped
  genvar gi;
  generate
    for (gi = 1; gi <= 3; gi++) begin : g_sp
      always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
          sp_reg[gi] <= '0;
        end else if (REG_WR_I && sp_ok && REG_ADDR_I == `TCS_ADDR_SP1 + 16'(2 * (gi - 1))) begin
          sp_reg[gi] <= $signed(REG_WDATA_I);
        end
      end
    end
  endgenerate
  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  tcs_act_t act_next;
  logic pulse_next;
  logic fsm_need;
  always_comb begin
    act_next = TCS_ACT_POSITION;
    pulse_next = 1'b0;
    fsm_need = 1'b0;
    case (mode_reg)
      `TCS_M_PT: pulse_next = 1'b1;
      `TCS_M_PR: fsm_need = 1'b1;
      `TCS_M_S, `TCS_M_SZ: act_next = TCS_ACT_SPEED;
      `TCS_M_T, `TCS_M_TZ: act_next = TCS_ACT_TORQUE;
      `TCS_M_PTS, `TCS_M_PRS: begin
        act_next = sp_sw ? TCS_ACT_SPEED : TCS_ACT_POSITION;
        fsm_need = ~sp_sw;
        pulse_next = (mode_reg == `TCS_M_PTS) & ~sp_sw;
      end
      `TCS_M_PTT, `TCS_M_PRT: begin
        act_next = st_sw ? TCS_ACT_TORQUE : TCS_ACT_POSITION;
        fsm_need = ~st_sw;
        pulse_next = (mode_reg == `TCS_M_PTT) & ~st_sw;
      end
      `TCS_M_ST: act_next = st_sw ? TCS_ACT_TORQUE : TCS_ACT_SPEED;
      `TCS_M_PTPR: begin
        fsm_need = ~sp_sw;
        pulse_next = sp_sw;
      end
      default: act_next = TCS_ACT_POSITION;
    endcase
  end
  // ------------------------------------------------------------
  // Position trigger sequencing
  // ------------------------------------------------------------
  tcs_pos_t pos_reg;
  tcs_pos_t pos_next;
  logic [5:0] target_reg;
  always_comb begin
    pos_next = pos_reg;
    case (pos_reg)
      TCS_PS_IDLE: if (fsm_need) pos_next = TCS_PS_WAIT;
      TCS_PS_WAIT: if (trig_rise) pos_next = TCS_PS_MOVE;
      TCS_PS_MOVE: pos_next = TCS_PS_MOVE;
      default: pos_next = TCS_PS_IDLE;
    endcase
    if (!fsm_need) begin
      pos_next = TCS_PS_IDLE;
    end
  end
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pos_reg <= TCS_PS_IDLE;
    end else begin
      pos_reg <= pos_next;
    end
  end
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      target_reg <= '0;
    end else if (fsm_need && pos_reg != TCS_PS_IDLE && trig_rise) begin
      target_reg <= psel_s;
    end
  end
  // Mode outputs
  tcs_act_t act_reg;
  logic limit_reg, pulse_reg, hold_reg;
  logic [1:0] ssel_reg;
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      act_reg <= TCS_ACT_POSITION;
      limit_reg <= 1'b1;
      pulse_reg <= 1'b0;
      hold_reg <= 1'b0;
      ssel_reg <= '0;
    end else begin
      act_reg <= act_next;
      limit_reg <= (act_next != TCS_ACT_TORQUE);
      pulse_reg <= pulse_next;
      hold_reg <= fsm_need & (pos_next != TCS_PS_MOVE);
      ssel_reg <= ssel_s;
    end
  end
  // ------------------------------------------------------------
  // Torque source selection
  // ------------------------------------------------------------
  logic [1:0] applied_reg;
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      applied_reg <= '0;
    end else if (servo_rise || (servo_s && tsel_s != applied_reg)) begin
      applied_reg <= tsel_s;
    end
  end
  // Analog clamp to +-10 V then scale to 0.1 % units
  logic signed [15:0] a_clamp;
  logic signed [31:0] a_prod;
  logic signed [19:0] analog_reg;
  always_comb begin
    a_clamp = ANALOG_REF_MV_I;
    if (ANALOG_REF_MV_I > $signed(`TCS_MV_FULL)) a_clamp = $signed(`TCS_MV_FULL);
    if (ANALOG_REF_MV_I < -$signed(`TCS_MV_FULL)) a_clamp = -$signed(`TCS_MV_FULL);
    a_prod = 32'(a_clamp) * 32'($signed({1'b0, scale_reg}));
  end
  logic signed [31:0] a_quot;
  assign a_quot = a_prod / $signed(`TCS_SCALE_DIV);
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      analog_reg <= '0;
    end else begin
      analog_reg <= a_quot[19:0];
    end
  end
  logic signed [19:0] src_next;
  logic signed [19:0] src_reg;
  always_comb begin
    if (!servo_s) begin
      src_next = '0;
    end else if (applied_reg == 2'b00) begin
      src_next = (mode_reg == `TCS_M_TZ) ? 20'sh00000 : analog_reg;
    end else begin
      src_next = 20'(sp_reg[applied_reg] * $signed(`TCS_PCT_TENTHS));
    end
  end
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      src_reg <= '0;
    end else begin
      src_reg <= src_next;
    end
  end
  // ------------------------------------------------------------
  // Smoothing filter
  // ------------------------------------------------------------
  localparam logic [31:0] CYC_W = 32'(CTRL_CYCLES);
  localparam logic [31:0] TC_US = 32'(`TCS_CTRL_CYCLE_US);
  logic [31:0] tick_cnt_reg;
  logic tick;
  assign tick = (tick_cnt_reg == CYC_W - 32'h00000001);
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
    end
  end
  // Coefficient k = Tc / (tau + Tc) in Q16
  logic [31:0] k_den;
  logic [31:0] k_full;
  logic [16:0] k_reg;
  assign k_den = 32'({16'h0000, filt_reg} * `TCS_MS_US) + TC_US;
  assign k_full = (TC_US << `TCS_QF) / k_den;
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      k_reg <= '0;
    end else begin
      k_reg <= k_full[16:0];
    end
  end
  logic signed [35:0] acc_reg;
  logic signed [35:0] x_q;
  logic signed [36:0] diff;
  logic signed [54:0] step;
  assign x_q = {src_reg, 16'h0000};
  assign diff = 37'(x_q) - 37'(acc_reg);
  assign step = diff * $signed({1'b0, k_reg});
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      acc_reg <= '0;
    end else if (tick) begin
      if (filt_reg == `TCS_RST_FILT) begin
        acc_reg <= x_q;
      end else begin
        acc_reg <= acc_reg + step[51:16];
      end
    end
  end
  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  logic [15:0] rdata_reg;
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata_reg <= '0;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        `TCS_ADDR_FILT: rdata_reg <= filt_reg;
        `TCS_ADDR_SCALE: rdata_reg <= scale_reg;
        `TCS_ADDR_MODE: rdata_reg <= {8'h00, mode_reg};
        `TCS_ADDR_SP1: rdata_reg <= sp_reg[1];
        `TCS_ADDR_SP2: rdata_reg <= sp_reg[2];
        `TCS_ADDR_SP3: rdata_reg <= sp_reg[3];
        `TCS_ADDR_STAT: rdata_reg <= {8'h00, servo_s, limit_reg, pos_reg, applied_reg, act_reg};
        `TCS_ADDR_TQ: rdata_reg <= acc_reg[31:16];
        default: rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end
  assign REG_RDATA_O = rdata_reg;
  assign TORQUE_CMD_O = acc_reg[35:16];
  assign TORQUE_IS_LIMIT_O = limit_reg;
  assign ACTIVE_MODE_O = act_reg;
  assign SPEED_SEL_O = ssel_reg;
  assign POS_FROM_PULSES_O = pulse_reg;
  assign MOTOR_HOLD_O = hold_reg;
  assign POS_MOVE_O = (pos_reg == TCS_PS_MOVE);
  assign POS_TARGET_O = target_reg;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  servo_off_zero_a: assert property (!servo_s |=> src_reg == 20'sh00000)
    else $error("torque source not zero with servo off");
  tz_zero_cmd_a: assert property (servo_s && applied_reg == 2'b00 && mode_reg == `TCS_M_TZ
    |=> src_reg == 20'sh00000)
    else $error("Tz mode did not force zero");
  analog_pass_a: assert property (servo_s && applied_reg == 2'b00 && mode_reg != `TCS_M_TZ
    |=> src_reg == $past(analog_reg))
    else $error("analog reference not selected");
  setpoint_sel_a: assert property (servo_s && applied_reg != 2'b00
    |=> src_reg == 20'($past(sp_reg[applied_reg]) * 10))
    else $error("stored setpoint not selected");
  sel_hold_a: assert property (servo_s && $stable(tsel_s) && $past(servo_s) && tsel_s == applied_reg
    |=> $stable(applied_reg))
    else $error("applied select moved without input change");
  sel_follow_a: assert property (servo_s && tsel_s != applied_reg |=> applied_reg == $past(tsel_s))
    else $error("applied select missed input change");
  bypass_a: assert property (tick && filt_reg == 16'h0000 |=> acc_reg == $past(x_q))
    else $error("zero time constant did not bypass");
  scale_a: assert property (analog_reg == 20'($past(a_prod) / 1000))
    else $error("analog scaling wrong");
  limit_flag_a: assert property (limit_reg == (act_reg != TCS_ACT_TORQUE))
    else $error("limit flag disagrees with mode");
  mode_legal_a: assert property (mode_reg inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0D})
    else $error("illegal control mode stored");
  sp_switch_a: assert property (mode_reg == `TCS_M_PRS && sp_sw
    |=> act_reg == TCS_ACT_SPEED && pos_reg == TCS_PS_IDLE)
    else $error("speed mode not entered on switch");
  hold_wait_a: assert property (mode_reg == `TCS_M_PRS && !sp_sw && pos_reg == TCS_PS_IDLE
    |=> pos_reg == TCS_PS_WAIT ##1 hold_reg)
    else $error("position wait not held");
  trig_latch_a: assert property (pos_reg == TCS_PS_WAIT && fsm_need && trig_rise
    |=> pos_reg == TCS_PS_MOVE && target_reg == $past(psel_s))
    else $error("trigger did not latch target");
  st_switch_a: assert property (mode_reg == `TCS_M_ST
    |=> act_reg == ($past(st_sw) ? TCS_ACT_TORQUE : TCS_ACT_SPEED))
    else $error("speed torque switch not followed");
  pulse_src_a: assert property (mode_reg == `TCS_M_PTS && !sp_sw |=> pulse_reg)
    else $error("pulse source not flagged");
  move_cov: cover property (pos_reg == TCS_PS_WAIT ##1 pos_reg == TCS_PS_MOVE);
  sp_cov: cover property (servo_s && applied_reg == 2'b11);
  st_cov: cover property (mode_reg == `TCS_M_ST && act_reg == TCS_ACT_TORQUE ##1
    act_reg == TCS_ACT_SPEED);
  filt_cov: cover property (tick && filt_reg != 16'h0000);
endmodule
`default_nettype wire

/* rtl/tcs_cfg.svh */
/*
  Constants of the torque command select and mode switch block.
  Assumes inclusion by bare name from the package and the design.
*/
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH
// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define TCS_ADDR_FILT 16'h010E
`define TCS_ADDR_SCALE 16'h0152
`define TCS_ADDR_MODE 16'h0102
`define TCS_ADDR_SP1 16'h0118
`define TCS_ADDR_SP2 16'h011A
`define TCS_ADDR_SP3 16'h011C
`define TCS_ADDR_STAT 16'h0300
`define TCS_ADDR_TQ 16'h0302
// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define TCS_RST_FILT 16'h0000
`define TCS_RST_SCALE 16'h0064
`define TCS_RST_MODE 8'h03
`define TCS_FILT_MAX 16'h03E8
`define TCS_SCALE_MAX 16'h03E8
`define TCS_SP_MAX 16'h012C
`define TCS_MV_FULL 16'h2710
`define TCS_SCALE_DIV 32'h000003E8
`define TCS_MS_US 32'h000003E8
`define TCS_PCT_TENTHS 20'h0000A
`define TCS_QF 16
// ------------------------------------------------------------
// Control mode codes
// ------------------------------------------------------------
`define TCS_M_PT 8'h00
`define TCS_M_PR 8'h01
`define TCS_M_S 8'h02
`define TCS_M_T 8'h03
`define TCS_M_SZ 8'h04
`define TCS_M_TZ 8'h05
`define TCS_M_PTS 8'h06
`define TCS_M_PTT 8'h07
`define TCS_M_PRS 8'h08
`define TCS_M_PRT 8'h09
`define TCS_M_ST 8'h0A
`define TCS_M_PTPR 8'h0D
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TCS_CLK_NS 10
`define TCS_CTRL_CYCLE_US 100
`endif

/* rtl/tcs_pkg.sv */
/*
  Types of the torque command select and mode switch block.
  Assumes tcs_cfg.svh on the include path.
*/
`include "tcs_cfg.svh"
package tcs_pkg;
  typedef enum logic [1:0] {
    TCS_ACT_POSITION = 2'b00,
    TCS_ACT_SPEED = 2'b01,
    TCS_ACT_TORQUE = 2'b10
  } tcs_act_t;
  typedef enum logic [1:0] {
    TCS_PS_IDLE = 2'b00,
    TCS_PS_WAIT = 2'b01,
    TCS_PS_MOVE = 2'b10
  } tcs_pos_t;
endpackage

/* testbench/tcs_ctrl_model.sv */
/*
  Behavioural model of the external motion controller driving the pins.
  Assumes the bench sets the wanted levels; each change lands after a random lag.
*/
`timescale 1ns/1ns
`default_nettype none
module tcs_ctrl_model (
  input wire logic clk_i,
  input wire logic [1:0] lag_i,
  input wire logic [13:0] want_i,
  input wire logic signed [15:0] want_mv_i,
  output logic [13:0] pins_o,
  output logic signed [15:0] mv_o
);
  logic [13:0] pins_reg = 14'h0000;
  logic signed [15:0] mv_reg = 16'sh0000;
  logic [1:0] wait_reg = 2'h0;
  assign pins_o = pins_reg;
  assign mv_o = mv_reg;
  // Level 1 drives a contact on, level 0 off
  always @(posedge clk_i) begin
    if (want_i != pins_reg || want_mv_i != mv_reg) begin
      if (wait_reg >= lag_i) begin
        pins_reg <= want_i;
        mv_reg <= want_mv_i;
        wait_reg <= 2'h0;
      end else begin
        wait_reg <= wait_reg + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
/*
  Self-checking bench of the torque select and mode switch block.
  Assumes rtl/ on the include path and the controller model compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tcs_cfg.svh"
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] rdata;
  // Wanted pins: servo, tsel[1:0], ssel[1:0], psel[5:0], trig, sp_sw, st_sw
  logic [13:0] want = 14'h0000;
  logic signed [15:0] want_mv = 16'sh0000;
  logic [1:0] lag = 2'h0;
  logic [13:0] pins;
  logic signed [15:0] mv;
  logic signed [19:0] tq;
  logic lim, hold, move, pulses;
  logic [1:0] act, ssel;
  logic [5:0] tgt;
  int seed, error_cnt, checked, i, m;
  logic [15:0] d;
  int sp[1:3];
  int codes[6] = '{6, 7, 8, 9, 10, 13};

  initial begin
    forever #5 clk = ~clk;
  end

  tcs_ctrl_model i_tcs_ctrl_model (.clk_i(clk), .lag_i(lag), .want_i(want), .want_mv_i(want_mv),
    .pins_o(pins), .mv_o(mv));

  tcs_top #(.CTRL_CYCLES(8)) i_tcs_top (.CLK_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr_s), .REG_RD_I(rd_s), .REG_RDATA_O(rdata),
    .SERVO_ON_I(pins[13]), .TORQUE_SELECT_I(pins[12:11]), .SPEED_SELECT_I(pins[10:9]),
    .POSITION_SELECT_I(pins[8:3]), .POSITION_TRIGGER_I(pins[2]), .SPEED_POS_SWITCH_I(pins[1]),
    .SPEED_TORQUE_SWITCH_I(pins[0]), .ANALOG_REF_MV_I(mv), .TORQUE_CMD_O(tq),
    .TORQUE_IS_LIMIT_O(lim), .ACTIVE_MODE_O(act), .SPEED_SEL_O(ssel), .POS_FROM_PULSES_O(pulses),
    .MOTOR_HOLD_O(hold), .POS_MOVE_O(move), .POS_TARGET_O(tgt));

  // ------------------------------------------------------------
  // Bus, pin and compare tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  // Lag plus sync plus two filter ticks
  task automatic settle();
    lag <= 2'(unsigned'($random(seed)) % 3);
    repeat (30) @(posedge clk);
  endtask

  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [19:0] exp_an(input int v, input int sc);
    return 20'(v * sc / 1000);
  endfunction

  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #500000;
    error_cnt++;
    summarize();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 14983;
    error_cnt = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(`TCS_ADDR_FILT, d); chk("filt_rst", 20'h00000, 20'(d));
    rd(`TCS_ADDR_SCALE, d); chk("scale_rst", 20'h00064, 20'(d));
    rd(`TCS_ADDR_MODE, d); chk("mode_rst", 20'h00003, 20'(d));
    rd(16'h0200, d); chk("unmapped", 20'h00000, 20'(d));
    wr(`TCS_ADDR_SCALE, 16'h03E9);
    rd(`TCS_ADDR_SCALE, d); chk("scale_refused", 20'h00064, 20'(d));
    want[13] <= 1'b1;
    for (i = 0; i < 6; i++) begin
      m = (i == 0) ? 10000 : (i == 1) ? -10000 : 10 * ($random(seed) % 1000);
      wr(`TCS_ADDR_SCALE, 16'(100 * (1 + i % 3)));
      want_mv <= 16'(m);
      settle();
      chk("analog_tq", exp_an(m, 100 * (1 + i % 3)), tq);
    end
    chk("t_limit", 20'h00000, 20'(lim));
    wr(`TCS_ADDR_MODE, 16'h0005);
    settle();
    chk("tz_zero", 20'h00000, tq);
    sp[1] = 300;
    sp[2] = -300;
    sp[3] = $random(seed) % 300;
    for (i = 1; i <= 3; i++) begin
      wr(16'(`TCS_ADDR_SP1 + 2 * (i - 1)), 16'(sp[i]));
    end
    wr(`TCS_ADDR_SP1, 16'h012D);
    rd(`TCS_ADDR_SP1, d); chk("sp_refused", 20'h0012C, 20'(d));
    for (i = 1; i <= 3; i++) begin
      want[12:11] <= 2'(i);
      settle();
      chk("setpoint_tq", 20'(sp[i] * 10), tq);
    end
    want[13] <= 1'b0;
    settle();
    chk("servo_off", 20'h00000, tq);
    want[13] <= 1'b1;
    settle();
    chk("servo_on", 20'(sp[3] * 10), tq);
    wr(`TCS_ADDR_MODE, 16'h0002);
    want[12:11] <= 2'b00;
    settle();
    chk("s_limit", 20'h00001, 20'(lim));
    chk("s_limit_val", exp_an(m, 300), tq);
    foreach (codes[j]) begin
      wr(`TCS_ADDR_MODE, 16'(codes[j]));
      rd(`TCS_ADDR_MODE, d); chk("dual_code", 20'(codes[j]), 20'(d));
    end
    wr(`TCS_ADDR_MODE, 16'h000B);
    rd(`TCS_ADDR_MODE, d); chk("code_refused", 20'h0000D, 20'(d));
    for (m = 6; m <= 8; m += 2) begin
      wr(`TCS_ADDR_MODE, 16'(m));
      want[10:9] <= 2'($random(seed));
      want[1] <= 1'b1;
      settle();
      chk("sp_speed", 20'h00001, 20'(act));
      chk("speed_sel", 20'(want[10:9]), 20'(ssel));
      want[2] <= 1'b1;
      settle();
      want[2] <= 1'b0;
      chk("trig_ignored", 20'h00000, 20'(move));
      want[1] <= 1'b0;
      settle();
      chk("pos_src", 20'(m == 6), 20'(pulses));
      chk("hold", 20'h00008, 20'({hold, move, act}));
      want[8:3] <= 6'($random(seed));
      settle();
      want[2] <= 1'b1;
      settle();
      chk("moving", 20'({1'b1, want[8:3]}), 20'({hold, move, tgt}));
      want[2] <= 1'b0;
      want[1] <= 1'b1;
      settle();
      chk("back_speed", 20'h00001, 20'({move, act}));
    end
    wr(`TCS_ADDR_MODE, 16'h000A);
    for (i = 0; i < 3; i++) begin
      want[0] <= ~want[0];
      settle();
      chk("st_mode", want[0] ? 20'h00002 : 20'h00005, 20'({lim, act}));
    end
    wr(`TCS_ADDR_MODE, 16'h000D);
    want[1] <= 1'b1;
    settle();
    chk("ptpr_pulse", 20'h00008, 20'({pulses, hold, act}));
    want[1] <= 1'b0;
    settle();
    chk("ptpr_wait", 20'h00004, 20'({pulses, hold, act}));
    wr(`TCS_ADDR_MODE, 16'h0003);
    wr(`TCS_ADDR_SCALE, 16'h0064);
    want_mv <= 16'sh0000;
    settle();
    wr(`TCS_ADDR_FILT, 16'h0005);
    want_mv <= 16'sd10000;
    settle();
    chk("filt_part", 20'h00001, 20'($signed(tq) > 0 && $signed(tq) < 1000));
    wr(`TCS_ADDR_FILT, 16'h0000);
    settle();
    chk("filt_bypass", 20'd1000, tq);
    rd(`TCS_ADDR_TQ, d); chk("tq_reg", 20'h003E8, 20'(d));
    rd(`TCS_ADDR_STAT, d); chk("status", 20'h00082, 20'(d));
    summarize();
  end
endmodule
`default_nettype wire
